// >>> rtl/port_gate_regs.vh
// Offsets, field positions and reset values of the port clock gating block
`ifndef PORT_GATE_REGS_VH
`define PORT_GATE_REGS_VH
`define RUN_PORT_GATE_OFS 12'h108
`define SLEEP_PORT_GATE_OFS 12'h118
`define DEEP_SLEEP_PORT_GATE_OFS 12'h128
`define RUN_CLOCK_CONFIG_OFS 12'h060
`define GATE_STATUS_OFS 12'h1F0
`define PORT_EN_MSB 4
`define PORT_EN_LSB 0
`define PORT_COUNT 5
`define SLEEP_SELECT_BIT 27
`define GATE_RESET 5'h00
`define MODE_RUN 2'h0
`define MODE_SLEEP 2'h1
`define MODE_DEEP_SLEEP 2'h2
`endif

// >>> rtl/port_access_guard.v
// Per-port gating: gated clock enable and bus fault on access to an unclocked port
`timescale 1ns/1ns
module port_access_guard #(
    parameter PORTS = 5
) (
    // Clock and reset
    input wire clk_sys,
    input wire rst_n,
    // Effective enables
    input wire [PORTS-1:0] port_en,
    // Port access requests, one bit per port
    input wire [PORTS-1:0] port_access,
    // Results
    output wire [PORTS-1:0] port_clock_en,
    output reg [PORTS-1:0] port_reset_n_q,
    output reg bus_fault_q
);
    genvar i;
    generate
        for (i = 0; i < PORTS; i = i + 1)
        begin : g_port
            // Reset follows the enable one cycle later, so an unclocked port is held disabled
            always @(posedge clk_sys)
            begin
                if (!rst_n)
                    port_reset_n_q[i] <= 1'b0;
                else
                    port_reset_n_q[i] <= port_en[i];
            end
        end
    endgenerate

    assign port_clock_en = port_en;

    always @(posedge clk_sys)
    begin
        if (!rst_n)
            bus_fault_q <= 1'b0;
        else
            bus_fault_q <= |(port_access & ~port_en);
    end
endmodule

// >>> rtl/port_clock_gating.v
// Port clock gating registers for run, sleep and deep-sleep operation
//
// Notes on behaviour
// - A set enable bit clocks its port; a clear bit leaves it unclocked and disabled.
// - Any access to a port whose clock is gated off ends in a bus fault, never normal data.
// - All sleep port enables read zero after reset.
// - Bits 4..0 enable ports E, D, C, B and A and are read-write.
// - Bits 31..5 are read-only, read zero and ignore writes.
// - Run enables apply in run; sleep enables in sleep and deep-sleep enables in deep sleep only while the sleep select bit is set, else run enables.
// - Sleep gating settings take effect only while the sleep select bit is set.
//
// Added by the designer: the strobed register port.
`timescale 1ns/1ns
`include "port_gate_regs.vh"
module port_clock_gating #(
    parameter PORTS = `PORT_COUNT
) (
    // Clock and reset
    input wire clk_sys,
    input wire rst_n,
    // Register port
    input wire [11:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [31:0] reg_rdata_q,
    // Power mode from the system controller
    input wire [1:0] power_mode,
    // Port accesses, one bit per port, pulse per bus cycle
    input wire [PORTS-1:0] port_access,
    // Port clocking
    output wire [PORTS-1:0] port_clock_en,
    output wire [PORTS-1:0] port_reset_n,
    output wire bus_fault
);
    reg [PORTS-1:0] run_gate_q;
    reg [PORTS-1:0] sleep_gate_q;
    reg [PORTS-1:0] deep_gate_q;
    reg sleep_select_q;
    reg [31:0] rd_word;
    wire [PORTS-1:0] eff_en;
    wire [PORTS-1:0] wr_en;
    wire [PORTS-1:0] rst_ports_n;
    // Address decode, one select per mapped register
    wire run_sel;
    wire sleep_sel;
    wire deep_sel;
    wire config_sel;
    wire status_sel;
    // Write strobes per register
    wire run_wr;
    wire sleep_wr;
    wire deep_wr;
    wire config_wr;
    wire [31:0] status_word;

    function [31:0] widen;
        input [PORTS-1:0] v;
        begin
            widen = 32'h0000_0000;
            widen[PORTS-1:0] = v;
        end
    endfunction

    function hit;
        input [11:0] a;
        input [11:0] ofs;
        begin
            hit = (a == ofs);
        end
    endfunction

    // Select bit gates both sleep tables, not only the sleep one
    function port_enable;
        input [1:0] mode;
        input sel;
        input run_bit;
        input sleep_bit;
        input deep_bit;
        begin
            case (mode)
                `MODE_RUN:
                    port_enable = run_bit;
                `MODE_SLEEP:
                    port_enable = sel ? sleep_bit : run_bit;
                `MODE_DEEP_SLEEP:
                    port_enable = sel ? deep_bit : run_bit;
                default:
                    port_enable = run_bit;
            endcase
        end
    endfunction

    // Reserved bits are never stored, so they cannot be written
    assign wr_en = reg_wdata[`PORT_EN_MSB:`PORT_EN_LSB];

    assign run_sel = hit(reg_addr, `RUN_PORT_GATE_OFS);
    assign sleep_sel = hit(reg_addr, `SLEEP_PORT_GATE_OFS);
    assign deep_sel = hit(reg_addr, `DEEP_SLEEP_PORT_GATE_OFS);
    assign config_sel = hit(reg_addr, `RUN_CLOCK_CONFIG_OFS);
    assign status_sel = hit(reg_addr, `GATE_STATUS_OFS);

    assign run_wr = reg_wr & run_sel;
    assign sleep_wr = reg_wr & sleep_sel;
    assign deep_wr = reg_wr & deep_sel;
    assign config_wr = reg_wr & config_sel;

    assign status_word = {14'h0000, power_mode, 11'h000, eff_en};

    // Run table, also the fallback while the select bit is clear
    always @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            run_gate_q <= `GATE_RESET;
        end
        else if (run_wr)
        begin
            run_gate_q <= wr_en;
        end
    end

    // Sleep table
    always @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            sleep_gate_q <= `GATE_RESET;
        end
        else if (sleep_wr)
        begin
            sleep_gate_q <= wr_en;
        end
    end

    // Deep-sleep table
    always @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            deep_gate_q <= `GATE_RESET;
        end
        else if (deep_wr)
        begin
            deep_gate_q <= wr_en;
        end
    end

    // Only the select bit of the configuration word lives here
    always @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            sleep_select_q <= 1'b0;
        end
        else if (config_wr)
        begin
            sleep_select_q <= reg_wdata[`SLEEP_SELECT_BIT];
        end
    end

    // Unmapped addresses read zero
    always @*
    begin
        rd_word = 32'h0000_0000;
        if (run_sel)
        begin
            rd_word = widen(run_gate_q);
        end
        else if (sleep_sel)
        begin
            rd_word = widen(sleep_gate_q);
        end
        else if (deep_sel)
        begin
            rd_word = widen(deep_gate_q);
        end
        else if (config_sel)
        begin
            rd_word = {4'h0, sleep_select_q, 27'h0000000};
        end
        else if (status_sel)
        begin
            rd_word = status_word;
        end
    end

    // Read data stands in the cycle after each read strobe, zero otherwise
    always @(posedge clk_sys)
    begin
        if (!rst_n)
            reg_rdata_q <= 32'h0000_0000;
        else if (reg_rd)
            reg_rdata_q <= rd_word;
        else
            reg_rdata_q <= 32'h0000_0000;
    end

    // One table pick per port
    genvar p;
    generate
        for (p = 0; p < PORTS; p = p + 1)
        begin : g_eff
            assign eff_en[p] = port_enable(power_mode, sleep_select_q, run_gate_q[p],
                sleep_gate_q[p], deep_gate_q[p]);
        end
    endgenerate

    port_access_guard #(
        .PORTS(PORTS)
    ) port_access_guard_inst (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .port_en(eff_en),
        .port_access(port_access),
        .port_clock_en(port_clock_en),
        .port_reset_n_q(rst_ports_n),
        .bus_fault_q(bus_fault)
    );

    assign port_reset_n = rst_ports_n;
endmodule

// >>> tb/sleep_port_clock_gating_properties.sv
// Port clock gating assertions
`timescale 1ns/1ns
module port_gate_checker #(parameter PORTS = 5) (
    // Watched ports
    input clk_sys, rst_n, reg_wr, reg_rd, bus_fault,
    input [11:0] reg_addr,
    input [31:0] reg_wdata, reg_rdata_q,
    input [1:0] power_mode,
    input [PORTS-1:0] port_access, port_clock_en, port_reset_n
);
    // Shadow state, so enables are judged without the bodies
    reg [PORTS-1:0] run_q, slp_q;
    reg sel_q;
    always @(posedge clk_sys)
    begin
        run_q <= !rst_n ? '0 : reg_wr && reg_addr == 12'h108 ? reg_wdata[PORTS-1:0] : run_q;
        slp_q <= !rst_n ? '0 : reg_wr && reg_addr == 12'h118 ? reg_wdata[PORTS-1:0] : slp_q;
        sel_q <= !rst_n ? 1'h0 : reg_wr && reg_addr == 12'h060 ? reg_wdata[27] : sel_q;
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    a_fault_gated: assert property (|(port_access & ~port_clock_en) |=> bus_fault)
        else $error("no fault");
    a_fault_spurious: assert property (!(|(port_access & ~port_clock_en)) |=> !bus_fault)
        else $error("spurious fault");
    a_reset_follow: assert property (port_reset_n == $past(port_clock_en))
        else $error("port reset wrong");
    a_sleep_readback: assert property (reg_rd && reg_addr == 12'h118
        |=> reg_rdata_q[PORTS-1:0] == $past(slp_q)) else $error("readback wrong");
    a_reserved_zero: assert property (reg_rd && reg_addr == 12'h118
        |=> reg_rdata_q[31:5] == 27'h0) else $error("reserved set");
    a_run_enables: assert property (power_mode == 2'h0 |-> port_clock_en == run_q)
        else $error("run wrong");
    a_sleep_enables: assert property (power_mode == 2'h1 && sel_q |-> port_clock_en == slp_q)
        else $error("sleep wrong");
    a_sleep_fallback: assert property (power_mode == 2'h1 && !sel_q |-> port_clock_en == run_q)
        else $error("fallback wrong");
endmodule
bind port_clock_gating port_gate_checker #(.PORTS(PORTS)) port_gate_checker_inst (.*);

// >>> tb/sleep_port_clock_gating_test.sv
// Bench for the port clock gating block
`timescale 1ns/1ns
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin errors++; \
    $display("MISMATCH %0t value differs", $time); end end
module sleep_port_clock_gating_test;
    reg clk_sys = 0, rst_n = 0, reg_wr = 0, reg_rd = 0;
    reg [11:0] reg_addr = 0;
    reg [31:0] reg_wdata = 0;
    reg [1:0] power_mode = 0;
    reg [4:0] port_access = 0;
    wire [31:0] reg_rdata_q;
    wire [4:0] port_clock_en, port_reset_n;
    wire bus_fault;
    int errors = 0, total_checks = 0;
    always #5 clk_sys = ~clk_sys;
    port_clock_gating port_clock_gating_inst (.*);
    // On a read, d is the expected word
    task op(input w, input [11:0] a, input [31:0] d);
    begin
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        {reg_wr, reg_rd} <= {w, !w};
        @(posedge clk_sys);
        {reg_wr, reg_rd} <= 2'h0;
        #1;
        if (!w) `CHK(reg_rdata_q, d)
    end
    endtask
    // Read-modify-write that keeps the reserved bits as read
    task t_rmw(input [4:0] set);
        reg [31:0] word;
    begin
        @(posedge clk_sys);
        reg_addr <= 12'h118;
        reg_rd <= 1;
        @(posedge clk_sys);
        reg_rd <= 0;
        #1 word = reg_rdata_q;
        @(posedge clk_sys);
        reg_wdata <= (word & 32'hFFFFFFE0) | set;
        reg_wr <= 1;
        @(posedge clk_sys);
        reg_wr <= 0;
    end
    endtask
    task step(input [1:0] m, input [4:0] p, input f, input [4:0] e);
    begin
        @(posedge clk_sys);
        power_mode <= m;
        port_access <= p;
        @(posedge clk_sys);
        port_access <= 0;
        #1;
        `CHK(port_clock_en, e)
        `CHK(port_reset_n, e)
        `CHK(bus_fault, f)
    end
    endtask
    task t_regs;
    begin
        op(0, 12'h118, 32'h0);
        step(2'h1, 5'h1F, 1, 5'h00);
        op(1, 12'h118, 32'hFFFFFFFF);
        op(0, 12'h118, 32'h1F);
        t_rmw(5'h05);
        op(0, 12'h118, 32'h5);
        op(0, 12'h7FC, 32'h0);
        $display("regs done");
    end
    endtask
    task t_modes;
    begin
        op(1, 12'h108, 32'h3);
        op(1, 12'h118, 32'h1C);
        step(2'h1, 5'h04, 1, 5'h03);
        op(1, 12'h060, 32'h08000000);
        step(2'h1, 5'h04, 0, 5'h1C);
        step(2'h0, 5'h10, 1, 5'h03);
        step(2'h2, 5'h01, 1, 5'h00);
        op(1, 12'h128, 32'hFFFFFFF1);
        step(2'h2, 5'h01, 0, 5'h11);
        op(0, 12'h1F0, 32'h00020011);
        op(0, 12'h060, 32'h08000000);
        step(2'h3, 5'h02, 0, 5'h03);
        op(0, 12'h108, 32'h3);
        $display("modes done");
    end
    endtask
    task print_verdict;
    begin
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    end
    endtask
    initial
    begin
        repeat (20) @(posedge clk_sys);
        rst_n <= 1;
        t_regs;
        t_modes;
        print_verdict;
    end
endmodule
